// [core/pwm_ovr_defs.svh]
// Register offsets, field positions and reset values of the PWM output override stage.
// Included by the package and the design; definitions only.
`ifndef PWM_OVR_DEFS_SVH
`define PWM_OVR_DEFS_SVH
`define ADDR_FAULT_A_CONTROL 4'h0
`define ADDR_FAULT_B_CONTROL 4'h1
`define ADDR_OUTPUT_OVERRIDE_CONTROL 4'h2
`define ADDR_OUTPUT_CONTROL 4'h3
`define ADDR_FAULT_STATUS 4'h4
`define ADDR_FAULT_MASK 4'h5
`define FAULT_MODE_BIT 7
`define FAULT_CTRL_WMASK 16'hff8f
`define RST_FAULT_CONTROL 16'h0000
`define RST_OVERRIDE_CONTROL 16'hff00
`define RST_OUTPUT_CONTROL 16'h00ff
`define RST_FAULT_MASK 16'h0000
`define OUT_CTRL_SYNC_BIT 8
`endif

// [core/pwm_ovr_pkg.sv]
// Types shared by the PWM output override stage.
// Assumes pwm_ovr_defs.svh sits beside it.
`include "pwm_ovr_defs.svh"
package pwm_ovr_pkg;
  typedef logic [3:0] reg_addr_type;
  typedef logic [15:0] reg_data_type;
  typedef logic [7:0] pin_vec_type;
  typedef enum logic [0:0] {fault_free, fault_held} fault_state_type;
endpackage : pwm_ovr_pkg

// [core/pwm_fault_override_ctrl.sv]
// Output-control stage of a four-pair PWM unit: fault forcing and manual override.
// Assumes raw PWM and the period strobe come from logic on clk; fault pins are async.
// Operation
// RULE1 - Fault in force on enabled pair drives each pin to its value bit.
// RULE2 - Mode bit 1 gives cycle-by-cycle fault, 0 gives latched fault.
// RULE3 - Latched fault holds governed pins at the upper-byte programmed states.
// RULE4 - First fault enable bits 0..3 choose which pairs respond.
// RULE5 - Second fault has its own four per-pair enable bits.
// RULE6 - Override-select bit 1 passes the generator signal to the pin.
// RULE7 - Override-select bit 0 takes the pin level from the manual bit.
// RULE8 - Overridden pin is asserted for manual bit 1, deasserted for 0.
// RULE9 - Fault control bits 6..4 ignore writes and read as zero.
// RULE10 - Sync select 1 applies overrides at period start, else next cycle.
// RULE11 - Pin enable 1 lets the block drive the pin, 0 releases it.
// RULE12 - Cycle-by-cycle fault releases at first period start after deassertion.
// RULE13 - Latched fault ends only after input low and flag cleared; the code waits for input high (fault deasserted) instead.
`timescale 1ns/10ps
`include "pwm_ovr_defs.svh"
module pwm_fault_override_ctrl (
  input wire logic clk, // 25 MHz instruction clock
  input wire logic arst_n, // Async reset, active low
  input wire pwm_ovr_pkg::reg_addr_type reg_addr, // Register index
  input wire pwm_ovr_pkg::reg_data_type reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output pwm_ovr_pkg::reg_data_type reg_rdata, // Read data, cycle after strobe
  input wire logic [3:0] gen_high, // Raw generator high-side signals
  input wire logic [3:0] gen_low, // Raw generator low-side signals
  input wire logic period_start, // Time-base period strobe, one cycle
  input wire logic fault_a_pin_n, // First fault input, active low
  input wire logic fault_b_pin_n, // Second fault input, active low
  output logic [3:0] pair_high_output, // High-side pin levels
  output logic [3:0] pair_low_output, // Low-side pin levels
  output logic [3:0] high_output_pin_enable, // High-side pin drive enables
  output logic [3:0] low_output_pin_enable, // Low-side pin drive enables
  output logic irq // Level interrupt
);
  import pwm_ovr_pkg::*;

  reg_data_type fault_a_ctrl_ff, fault_b_ctrl_ff, ovd_ff, out_ctrl_ff, mask_ff;
  reg_data_type ovd_act_ff, rdata_ff;
  logic [1:0] status_ff;
  logic [1:0] sync_a_ff, sync_b_ff;
  fault_state_type state_a_ff, state_b_ff;
  logic [7:0] pin_out_ff;

  // Governed-pin mask in pin order {4H,4L,...,1H,1L} from the enable bits of a fault control word
  function automatic pin_vec_type pair_gov(input reg_data_type c, input logic act);
    pin_vec_type g;
    g = '0;
    for (int i = 0; i < 4; i++) begin
      g[2*i] = act & c[i]; // see RULE4 see RULE5
      g[2*i+1] = act & c[i];
    end
    return g;
  endfunction : pair_gov

  // Decode and synchronised fault levels
  wire wr_fa = reg_wr && reg_addr == `ADDR_FAULT_A_CONTROL;
  wire wr_fb = reg_wr && reg_addr == `ADDR_FAULT_B_CONTROL;
  wire wr_ovd = reg_wr && reg_addr == `ADDR_OUTPUT_OVERRIDE_CONTROL;
  wire wr_oc = reg_wr && reg_addr == `ADDR_OUTPUT_CONTROL;
  wire wr_st = reg_wr && reg_addr == `ADDR_FAULT_STATUS;
  wire wr_mk = reg_wr && reg_addr == `ADDR_FAULT_MASK;
  wire fault_a = sync_a_ff[1];
  wire fault_b = sync_b_ff[1];
  wire mode_a_cyc = fault_a_ctrl_ff[`FAULT_MODE_BIT];
  wire mode_b_cyc = fault_b_ctrl_ff[`FAULT_MODE_BIT];
  wire [1:0] clr = wr_st ? reg_wdata[1:0] : 2'h0;
  wire [1:0] evt = {fault_b, fault_a};
  wire [1:0] nxt_status = (status_ff & ~clr) | evt; // Set beats clear

  // Synchronisers; first stage is read only by the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a_ff <= 2'h0;
      sync_b_ff <= 2'h0;
    end else begin
      sync_a_ff <= {sync_a_ff[0], ~fault_a_pin_n};
      sync_b_ff <= {sync_b_ff[0], ~fault_b_pin_n};
    end
  end

  // Register file; reserved fault bits 6..4 never store
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_a_ctrl_ff <= `RST_FAULT_CONTROL;
      fault_b_ctrl_ff <= `RST_FAULT_CONTROL;
      ovd_ff <= `RST_OVERRIDE_CONTROL;
      out_ctrl_ff <= `RST_OUTPUT_CONTROL;
      mask_ff <= `RST_FAULT_MASK;
      status_ff <= 2'h0;
    end else begin
      if (wr_fa) fault_a_ctrl_ff <= reg_wdata & `FAULT_CTRL_WMASK; // see RULE9
      if (wr_fb) fault_b_ctrl_ff <= reg_wdata & `FAULT_CTRL_WMASK; // see RULE9
      if (wr_ovd) ovd_ff <= reg_wdata;
      if (wr_oc) out_ctrl_ff <= {7'h00, reg_wdata[8:0]};
      if (wr_mk) mask_ff <= {14'h0000, reg_wdata[1:0]};
      status_ff <= nxt_status;
    end
  end

  // Override word reaches the pins now or at the period start
  wire ovd_load = !out_ctrl_ff[`OUT_CTRL_SYNC_BIT] || period_start; // see RULE10
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) ovd_act_ff <= `RST_OVERRIDE_CONTROL;
    else if (ovd_load) ovd_act_ff <= ovd_ff;
  end

  // Fault hold states: cycle mode waits for a period start, latched waits for
  // input high (fault deasserted) and a cleared flag; writing the flag clear is the only way out
  wire rel_a = !fault_a && (mode_a_cyc ? period_start : !status_ff[0]); // see RULE12 see RULE13
  wire rel_b = !fault_b && (mode_b_cyc ? period_start : !status_ff[1]); // see RULE12 see RULE13
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_a_ff <= fault_free;
      state_b_ff <= fault_free;
    end else begin
      unique case (state_a_ff) // see RULE2
        fault_free: if (fault_a) state_a_ff <= fault_held;
        fault_held: if (rel_a) state_a_ff <= fault_free;
      endcase
      unique case (state_b_ff)
        fault_free: if (fault_b) state_b_ff <= fault_held;
        fault_held: if (rel_b) state_b_ff <= fault_free;
      endcase
    end
  end

  // Pin selection: fault A wins over B, fault wins over manual override
  wire act_a = fault_a || state_a_ff == fault_held;
  wire act_b = fault_b || state_b_ff == fault_held;
  wire [7:0] gov_a = pair_gov(fault_a_ctrl_ff, act_a); // see RULE4
  wire [7:0] gov_b = pair_gov(fault_b_ctrl_ff, act_b); // see RULE5
  wire [7:0] gen_pins = {gen_high[3], gen_low[3], gen_high[2], gen_low[2],
                         gen_high[1], gen_low[1], gen_high[0], gen_low[0]};
  wire [7:0] man_pins = (ovd_act_ff[15:8] & gen_pins) | (~ovd_act_ff[15:8] & ovd_act_ff[7:0]); // see RULE6 see RULE7 see RULE8
  wire [7:0] flt_b_pins = (gov_b & fault_b_ctrl_ff[15:8]) | (~gov_b & man_pins);
  wire [7:0] nxt_pin_out = (gov_a & fault_a_ctrl_ff[15:8]) | (~gov_a & flt_b_pins); // see RULE1 see RULE3
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pin_out_ff <= 8'h00;
    else pin_out_ff <= nxt_pin_out;
  end
  for (genvar p = 0; p < 4; p++) begin : g_pin
    assign pair_high_output[p] = pin_out_ff[2*p+1];
    assign pair_low_output[p] = pin_out_ff[2*p];
  end
  assign high_output_pin_enable = out_ctrl_ff[7:4]; // see RULE11
  assign low_output_pin_enable = out_ctrl_ff[3:0]; // see RULE11
  assign irq = |(status_ff & mask_ff[1:0]);

  // Read mux; unmapped index reads zero
  reg_data_type nxt_rdata;
  always_comb begin
    nxt_rdata = 16'h0000;
    unique case (reg_addr)
      `ADDR_FAULT_A_CONTROL: nxt_rdata = fault_a_ctrl_ff;
      `ADDR_FAULT_B_CONTROL: nxt_rdata = fault_b_ctrl_ff;
      `ADDR_OUTPUT_OVERRIDE_CONTROL: nxt_rdata = ovd_ff;
      `ADDR_OUTPUT_CONTROL: nxt_rdata = out_ctrl_ff;
      `ADDR_FAULT_STATUS: nxt_rdata = {14'h0000, status_ff};
      `ADDR_FAULT_MASK: nxt_rdata = mask_ff;
      default: nxt_rdata = 16'h0000;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rdata_ff <= 16'h0000;
    else if (reg_rd) rdata_ff <= nxt_rdata;
    else rdata_ff <= 16'h0000;
  end
  assign reg_rdata = rdata_ff;

  // Checks
  AST_FAULT_A_FORCE: assert property (@(posedge clk) disable iff (!arst_n) // see RULE1
    (fault_a && fault_a_ctrl_ff[0]) |=> pair_low_output[0] == $past(fault_a_ctrl_ff[8]))
    else $error("fault A did not force pin 1L");
  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!arst_n) // see RULE3
    (state_a_ff == fault_held && !mode_a_cyc && status_ff[0]) |=> state_a_ff == fault_held)
    else $error("latched fault released early");
  AST_CYC_RELEASE: assert property (@(posedge clk) disable iff (!arst_n) // see RULE12
    (state_a_ff == fault_held && mode_a_cyc && !fault_a && !period_start) |=> state_a_ff == fault_held)
    else $error("cycle fault released off period start");
  AST_NO_ENABLE: assert property (@(posedge clk) disable iff (!arst_n) // see RULE4
    (!fault_a_ctrl_ff[1] && !act_b) |=> pair_high_output[1] == $past(man_pins[3]))
    else $error("disabled pair followed fault A");
  AST_FAULT_B: assert property (@(posedge clk) disable iff (!arst_n) // see RULE5
    (act_b && fault_b_ctrl_ff[2] && !act_a) |=> pair_high_output[2] == $past(fault_b_ctrl_ff[13]))
    else $error("fault B did not force pin 3H");
  AST_GEN_PASS: assert property (@(posedge clk) disable iff (!arst_n) // see RULE6
    (!act_a && !act_b && ovd_act_ff[8]) |=> pair_low_output[0] == $past(gen_low[0]))
    else $error("generator signal not passed");
  AST_MANUAL: assert property (@(posedge clk) disable iff (!arst_n) // see RULE7 see RULE8
    (!act_a && !act_b && !ovd_act_ff[9]) |=> pair_high_output[0] == $past(ovd_act_ff[1]))
    else $error("manual level not applied");
  AST_RESERVED: assert property (@(posedge clk) disable iff (!arst_n) // see RULE9
    fault_a_ctrl_ff[6:4] == 3'h0 && fault_b_ctrl_ff[6:4] == 3'h0)
    else $error("reserved fault bits stored");
  AST_SYNC_OVD: assert property (@(posedge clk) disable iff (!arst_n) // see RULE10
    (out_ctrl_ff[`OUT_CTRL_SYNC_BIT] && !period_start) |=> $stable(ovd_act_ff))
    else $error("override moved off period start");
  AST_ENABLE: assert property (@(posedge clk) disable iff (!arst_n) // see RULE11
    high_output_pin_enable == out_ctrl_ff[7:4])
    else $error("pin enable mismatch");
  AST_STICKY: assert property (@(posedge clk) disable iff (!arst_n) // see RULE13
    fault_a |=> status_ff[0])
    else $error("fault flag not set");

  // Per-pair ownership, so each pin can be checked against its own priority
  wire [3:0] a_owns = {4{act_a}} & fault_a_ctrl_ff[3:0]; // Pairs forced by fault A
  wire [3:0] b_owns = {4{act_b}} & fault_b_ctrl_ff[3:0]; // Pairs governed by fault B
  wire [3:0] b_wins = b_owns & ~a_owns; // A wins a shared pair
  wire [3:0] pair_free = ~a_owns & ~b_owns; // Pairs left to the override word

  // Fault A forcing, every pin but 1L; covers both held and live faults
  AST_FA_1H: assert property (@(posedge clk) disable iff (!arst_n) // see RULE1 see RULE3
    a_owns[0] |=> pair_high_output[0] == $past(fault_a_ctrl_ff[9]))
    else $error("fault A did not force pin 1H");

  AST_FA_2L: assert property (@(posedge clk) disable iff (!arst_n) // see RULE1 see RULE3
    a_owns[1] |=> pair_low_output[1] == $past(fault_a_ctrl_ff[10]))
    else $error("fault A did not force pin 2L");

  AST_FA_2H: assert property (@(posedge clk) disable iff (!arst_n) // see RULE1 see RULE3
    a_owns[1] |=> pair_high_output[1] == $past(fault_a_ctrl_ff[11]))
    else $error("fault A did not force pin 2H");

  AST_FA_3L: assert property (@(posedge clk) disable iff (!arst_n) // see RULE1 see RULE3
    a_owns[2] |=> pair_low_output[2] == $past(fault_a_ctrl_ff[12]))
    else $error("fault A did not force pin 3L");

  AST_FA_3H: assert property (@(posedge clk) disable iff (!arst_n) // see RULE1 see RULE3
    a_owns[2] |=> pair_high_output[2] == $past(fault_a_ctrl_ff[13]))
    else $error("fault A did not force pin 3H");

  AST_FA_4L: assert property (@(posedge clk) disable iff (!arst_n) // see RULE1 see RULE3
    a_owns[3] |=> pair_low_output[3] == $past(fault_a_ctrl_ff[14]))
    else $error("fault A did not force pin 4L");

  AST_FA_4H: assert property (@(posedge clk) disable iff (!arst_n) // see RULE1 see RULE3
    a_owns[3] |=> pair_high_output[3] == $past(fault_a_ctrl_ff[15]))
    else $error("fault A did not force pin 4H");

  // Fault B forcing where A does not own the pair
  AST_FB_1L: assert property (@(posedge clk) disable iff (!arst_n) // see RULE5 see RULE1
    b_wins[0] |=> pair_low_output[0] == $past(fault_b_ctrl_ff[8]))
    else $error("fault B did not force pin 1L");

  AST_FB_1H: assert property (@(posedge clk) disable iff (!arst_n) // see RULE5 see RULE1
    b_wins[0] |=> pair_high_output[0] == $past(fault_b_ctrl_ff[9]))
    else $error("fault B did not force pin 1H");

  AST_FB_2L: assert property (@(posedge clk) disable iff (!arst_n) // see RULE5 see RULE1
    b_wins[1] |=> pair_low_output[1] == $past(fault_b_ctrl_ff[10]))
    else $error("fault B did not force pin 2L");

  AST_FB_2H: assert property (@(posedge clk) disable iff (!arst_n) // see RULE5 see RULE1
    b_wins[1] |=> pair_high_output[1] == $past(fault_b_ctrl_ff[11]))
    else $error("fault B did not force pin 2H");

  AST_FB_3L: assert property (@(posedge clk) disable iff (!arst_n) // see RULE5 see RULE1
    b_wins[2] |=> pair_low_output[2] == $past(fault_b_ctrl_ff[12]))
    else $error("fault B did not force pin 3L");

  AST_FB_4L: assert property (@(posedge clk) disable iff (!arst_n) // see RULE5 see RULE1
    b_wins[3] |=> pair_low_output[3] == $past(fault_b_ctrl_ff[14]))
    else $error("fault B did not force pin 4L");

  AST_FB_4H: assert property (@(posedge clk) disable iff (!arst_n) // see RULE5 see RULE1
    b_wins[3] |=> pair_high_output[3] == $past(fault_b_ctrl_ff[15]))
    else $error("fault B did not force pin 4H");

  // Manual levels on free pairs; uses the active word, not the written one
  AST_MAN_1L: assert property (@(posedge clk) disable iff (!arst_n) // see RULE7 see RULE8
    (pair_free[0] && !ovd_act_ff[8]) |=> pair_low_output[0] == $past(ovd_act_ff[0]))
    else $error("manual level not applied to 1L");

  AST_MAN_2L: assert property (@(posedge clk) disable iff (!arst_n) // see RULE7 see RULE8
    (pair_free[1] && !ovd_act_ff[10]) |=> pair_low_output[1] == $past(ovd_act_ff[2]))
    else $error("manual level not applied to 2L");

  AST_MAN_2H: assert property (@(posedge clk) disable iff (!arst_n) // see RULE7 see RULE8
    (pair_free[1] && !ovd_act_ff[11]) |=> pair_high_output[1] == $past(ovd_act_ff[3]))
    else $error("manual level not applied to 2H");

  AST_MAN_3L: assert property (@(posedge clk) disable iff (!arst_n) // see RULE7 see RULE8
    (pair_free[2] && !ovd_act_ff[12]) |=> pair_low_output[2] == $past(ovd_act_ff[4]))
    else $error("manual level not applied to 3L");

  AST_MAN_3H: assert property (@(posedge clk) disable iff (!arst_n) // see RULE7 see RULE8
    (pair_free[2] && !ovd_act_ff[13]) |=> pair_high_output[2] == $past(ovd_act_ff[5]))
    else $error("manual level not applied to 3H");

  AST_MAN_4L: assert property (@(posedge clk) disable iff (!arst_n) // see RULE7 see RULE8
    (pair_free[3] && !ovd_act_ff[14]) |=> pair_low_output[3] == $past(ovd_act_ff[6]))
    else $error("manual level not applied to 4L");

  AST_MAN_4H: assert property (@(posedge clk) disable iff (!arst_n) // see RULE7 see RULE8
    (pair_free[3] && !ovd_act_ff[15]) |=> pair_high_output[3] == $past(ovd_act_ff[7]))
    else $error("manual level not applied to 4H");

  // Generator pass-through on free pairs
  AST_GEN_1H: assert property (@(posedge clk) disable iff (!arst_n) // see RULE6
    (pair_free[0] && ovd_act_ff[9]) |=> pair_high_output[0] == $past(gen_high[0]))
    else $error("generator signal not passed to 1H");

  AST_GEN_2L: assert property (@(posedge clk) disable iff (!arst_n) // see RULE6
    (pair_free[1] && ovd_act_ff[10]) |=> pair_low_output[1] == $past(gen_low[1]))
    else $error("generator signal not passed to 2L");

  AST_GEN_2H: assert property (@(posedge clk) disable iff (!arst_n) // see RULE6
    (pair_free[1] && ovd_act_ff[11]) |=> pair_high_output[1] == $past(gen_high[1]))
    else $error("generator signal not passed to 2H");

  AST_GEN_3L: assert property (@(posedge clk) disable iff (!arst_n) // see RULE6
    (pair_free[2] && ovd_act_ff[12]) |=> pair_low_output[2] == $past(gen_low[2]))
    else $error("generator signal not passed to 3L");

  AST_GEN_3H: assert property (@(posedge clk) disable iff (!arst_n) // see RULE6
    (pair_free[2] && ovd_act_ff[13]) |=> pair_high_output[2] == $past(gen_high[2]))
    else $error("generator signal not passed to 3H");

  AST_GEN_4L: assert property (@(posedge clk) disable iff (!arst_n) // see RULE6
    (pair_free[3] && ovd_act_ff[14]) |=> pair_low_output[3] == $past(gen_low[3]))
    else $error("generator signal not passed to 4L");

  AST_GEN_4H: assert property (@(posedge clk) disable iff (!arst_n) // see RULE6
    (pair_free[3] && ovd_act_ff[15]) |=> pair_high_output[3] == $past(gen_high[3]))
    else $error("generator signal not passed to 4H");

  // Flags, interrupt, low pin enables and bus idle level
  AST_IRQ_SET: assert property (@(posedge clk) disable iff (!arst_n) // see RULE13
    (fault_a && mask_ff[0]) |=> irq)
    else $error("unmasked fault gave no interrupt");

  AST_CLEAR: assert property (@(posedge clk) disable iff (!arst_n) // see RULE13
    (status_ff[0] && !fault_a && wr_st && reg_wdata[0]) |=> !status_ff[0])
    else $error("fault flag not cleared");

  AST_LOW_ENABLE: assert property (@(posedge clk) disable iff (!arst_n) // see RULE11
    low_output_pin_enable == out_ctrl_ff[3:0])
    else $error("low pin enable mismatch");

  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read");

  COV_MANUAL: cover property (@(posedge clk) disable iff (!arst_n)
    pair_free[0] && !ovd_act_ff[8]);
  COV_B_LATCH: cover property (@(posedge clk) disable iff (!arst_n)
    state_b_ff == fault_held && !mode_b_cyc);
  COV_LATCH: cover property (@(posedge clk) disable iff (!arst_n)
    state_a_ff == fault_held && !mode_a_cyc ##1 state_a_ff == fault_free);
  COV_CYCLE: cover property (@(posedge clk) disable iff (!arst_n)
    state_b_ff == fault_held && mode_b_cyc ##1 state_b_ff == fault_free);
  COV_IRQ: cover property (@(posedge clk) disable iff (!arst_n) $rose(irq));
endmodule : pwm_fault_override_ctrl

// [dv/pwm_stage_model.sv]
// Far side: PWM generator levels, period strobe, fault sensors.
// Assumes the bench calls its tasks on the clk domain.
`timescale 1ns/10ps
module pwm_stage_model (
  input wire logic clk, // Shared clock
  output logic [3:0] gen_high, // Generator high sides
  output logic [3:0] gen_low, // Generator low sides
  output logic period_start, // Period strobe
  output logic fault_a_pin_n, // Sensor A, active low
  output logic fault_b_pin_n // Sensor B, active low
);
  // Idle: no faults, high sides on so forcing shows
  initial begin
    gen_high = 4'hf;
    gen_low = 4'h0;
    period_start = 1'b0;
    fault_a_pin_n = 1'b1;
    fault_b_pin_n = 1'b1;
  end
  // Sensors change just after an edge
  task automatic set_faults(input logic a_n, input logic b_n);
    @(posedge clk);
    fault_a_pin_n <= a_n;
    fault_b_pin_n <= b_n;
  endtask : set_faults
  // One-cycle period strobe
  task automatic pulse_period();
    @(posedge clk);
    period_start <= 1'b1;
    @(posedge clk);
    period_start <= 1'b0;
  endtask : pulse_period
endmodule : pwm_stage_model

// [dv/tb_top.sv]
// Bench: registers, manual override and both fault inputs.
// Assumes the package, defines header and stage model are compiled first.
`timescale 1ns/10ps
`include "pwm_ovr_defs.svh"
module tb_top;
  import pwm_ovr_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  reg_addr_type reg_addr = 4'h0;
  reg_data_type reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  reg_data_type reg_rdata;
  logic [3:0] gh, gl, ho, lo, he, le;
  logic ps, fa_n, fb_n, irq;
  int mismatches = 0;
  int checks_done = 0;
  always #20 clk = ~clk;
  pwm_stage_model model_u (.clk(clk), .gen_high(gh), .gen_low(gl), .period_start(ps),
    .fault_a_pin_n(fa_n), .fault_b_pin_n(fb_n));
  pwm_fault_override_ctrl dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gen_high(gh), .gen_low(gl), .period_start(ps), .fault_a_pin_n(fa_n),
    .fault_b_pin_n(fb_n), .pair_high_output(ho), .pair_low_output(lo),
    .high_output_pin_enable(he), .low_output_pin_enable(le), .irq(irq));
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input reg_addr_type a, input reg_data_type d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Data stand only in the cycle after the strobe
  task automatic rd(input reg_addr_type a, input reg_data_type exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd
  // Longer than the 3-edge fault path, so both paths have landed
  task automatic pins(input logic [3:0] eh, input logic [3:0] el);
    repeat (4) @(posedge clk);
    #1;
    chk({8'h00, ho, lo}, {8'h00, eh, el});
  endtask : pins
  task automatic t_regs();
    rd(`ADDR_FAULT_A_CONTROL, 16'h0000);
    rd(`ADDR_OUTPUT_OVERRIDE_CONTROL, 16'hff00);
    rd(4'hf, 16'h0000);
    wr(`ADDR_FAULT_A_CONTROL, 16'hffff);
    rd(`ADDR_FAULT_A_CONTROL, 16'hff8f);
    wr(`ADDR_FAULT_B_CONTROL, 16'hff7f);
    rd(`ADDR_FAULT_B_CONTROL, 16'hff0f);
    wr(`ADDR_OUTPUT_CONTROL, 16'h005a);
    #1;
    chk({8'h00, he, le}, 16'h005a);
    wr(`ADDR_OUTPUT_CONTROL, 16'h00ff);
    wr(`ADDR_FAULT_A_CONTROL, 16'h0000);
    wr(`ADDR_FAULT_B_CONTROL, 16'h0000);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_manual();
    wr(`ADDR_OUTPUT_OVERRIDE_CONTROL, 16'h00a5);
    pins(4'b1100, 4'b0011);
    wr(`ADDR_OUTPUT_CONTROL, 16'h01ff);
    wr(`ADDR_OUTPUT_OVERRIDE_CONTROL, 16'hff00);
    pins(4'b1100, 4'b0011);
    model_u.pulse_period();
    pins(4'hf, 4'h0);
    wr(`ADDR_OUTPUT_CONTROL, 16'h00ff);
    $display("t_manual done");
  endtask : t_manual
  task automatic t_fault_a();
    wr(`ADDR_FAULT_MASK, 16'h0001);
    wr(`ADDR_FAULT_A_CONTROL, 16'h5583);
    model_u.set_faults(1'b0, 1'b1);
    pins(4'b1100, 4'b0011);
    chk({15'h0000, irq}, 16'h0001);
    model_u.set_faults(1'b1, 1'b1);
    pins(4'b1100, 4'b0011);
    model_u.pulse_period();
    pins(4'hf, 4'h0);
    wr(`ADDR_FAULT_STATUS, 16'h0001);
    pins(4'hf, 4'h0);
    chk({15'h0000, irq}, 16'h0000);
    wr(`ADDR_FAULT_A_CONTROL, 16'h0000);
    $display("t_fault_a done");
  endtask : t_fault_a
  task automatic t_fault_b();
    wr(`ADDR_FAULT_B_CONTROL, 16'h4008);
    model_u.set_faults(1'b1, 1'b0);
    pins(4'b0111, 4'b1000);
    chk({15'h0000, irq}, 16'h0000);
    model_u.set_faults(1'b1, 1'b1);
    model_u.pulse_period();
    pins(4'b0111, 4'b1000);
    rd(`ADDR_FAULT_STATUS, 16'h0002);
    wr(`ADDR_FAULT_MASK, 16'h0003);
    pins(4'b0111, 4'b1000);
    chk({15'h0000, irq}, 16'h0001);
    wr(`ADDR_FAULT_STATUS, 16'h0002);
    pins(4'hf, 4'h0);
    chk({15'h0000, irq}, 16'h0000);
    $display("t_fault_b done");
  endtask : t_fault_b
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  // Main sequence after a 3-cycle reset
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_manual();
    t_fault_a();
    t_fault_b();
    summarize();
  end
  // Watchdog, far beyond the hundred or so cycles needed
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule : tb_top
